// ---- rtl/rac_pkg.sv ----
// register access conventions bank: shared constants
package rac_pkg;
   // ********************************************************
   // widths
   // ********************************************************
   localparam int DATA_W = 8;
   localparam int ADDR_W = 3;
   // ********************************************************
   // register index map
   // ********************************************************
   localparam logic [2:0] CTRL_ADDR = 3'h0;
   localparam logic [2:0] STATUS_ADDR = 3'h1;
   localparam logic [2:0] CMD_ADDR = 3'h2;
   localparam logic [2:0] DBGCTRL_ADDR = 3'h3;
   localparam logic [2:0] OUT_SET_ADDR = 3'h4;
   localparam logic [2:0] CLEAR_ALIAS_REGISTER_ADDR = 3'h5;
   // ********************************************************
   // field positions and implemented-bit masks
   // ********************************************************
   localparam int CTRL_ENABLE_BIT = 0;
   localparam int CTRL_MODE_LSB = 2;
   localparam int CTRL_MODE_MSB = 3;
   localparam logic [7:0] CTRL_MASK = 8'h0d;
   localparam int STATUS_BUSY_BIT = 0;
   localparam int STATUS_LEVEL_LSB = 1;
   localparam int STATUS_LEVEL_MSB = 2;
   localparam logic [7:0] STATUS_MASK = 8'h07;
   localparam int CMD_SWRST_BIT = 0;
   localparam int CMD_STROBE_BIT = 1;
   localparam int DBG_RUN_BIT = 0;
   localparam logic [7:0] DBG_MASK = 8'h01;
   // ********************************************************
   // encodings
   // ********************************************************
   localparam logic [1:0] LEVEL_RESERVED = 2'h3;
   localparam logic [1:0] LEVEL_MAX = 2'h2;
   // ********************************************************
   // reset values
   // ********************************************************
   localparam logic [7:0] CTRL_RST = 8'h00;
   localparam logic [7:0] STATUS_RST = 8'h00;
   localparam logic [7:0] DBG_RST = 8'h00;
   localparam logic [7:0] OUT_RST = 8'h00;
   localparam logic [7:0] RDATA_RST = 8'h00;
endpackage

// ---- rtl/rac_setclr.sv ----
// one set/clear aliased register with clear priority
`timescale 1ns/1ps
module rac_setclr #(
   parameter int WIDTH = 8,
   parameter logic [WIDTH-1:0] RST_VAL = '0
) (
   // clock, reset, enable
   input wire logic i_clk,
   input wire logic i_rst_n,
   input wire logic i_ce,
   input wire logic i_soft_rst,
   // alias write masks
   input wire logic [WIDTH-1:0] i_set_mask,
   input wire logic [WIDTH-1:0] i_clear_mask,
   // stored value
   output logic [WIDTH-1:0] o_q
);
   logic [WIDTH-1:0] q_reg;
   logic [WIDTH-1:0] q_next;

   // zero bits in both masks keep the stored bit
   // clear applied last, so it wins a double write
   assign q_next = (q_reg | i_set_mask) & ~i_clear_mask;

   always_ff @(posedge i_clk) begin
      if (!i_rst_n || (i_ce && i_soft_rst)) begin
         q_reg <= RST_VAL;
      end else if (i_ce) begin
         q_reg <= q_next;
      end
   end

   assign o_q = q_reg;

   // ********************************************************
   // checks
   // ********************************************************
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_rst_n);

   sequence s_plain_write;
      i_ce && !i_soft_rst;
   endsequence

   a_clear_bit_zero: assert property (s_plain_write |=> ((q_reg & $past(i_clear_mask)) == '0))
      else $error("clear alias bit did not clear");
   a_set_bit_one: assert property (s_plain_write |=>
      ((q_reg & ($past(i_set_mask) & ~$past(i_clear_mask))) == ($past(i_set_mask) & ~$past(i_clear_mask))))
      else $error("set alias bit did not set");
   a_clear_wins_both: assert property (s_plain_write ##0 ((i_set_mask & i_clear_mask) != '0)
      |=> ((q_reg & $past(i_set_mask & i_clear_mask)) == '0))
      else $error("set beat clear on a double write");
   a_zero_keeps_bit: assert property (s_plain_write |=>
      ((q_reg & ~$past(i_set_mask | i_clear_mask)) == ($past(q_reg) & ~$past(i_set_mask | i_clear_mask))))
      else $error("unwritten bit changed");
endmodule // rac_setclr

// ---- rtl/rac_bank.sv ----
// register bank applying read-only, write-only, reserved, reset and set/clear conventions
//
// Function
// - read-only bits ignore writes and still read back their value
// - write-only bits accept writes; reads give no dependable value
// - reserved bit positions always read as zero
// - a read-only field never shows a reserved encoding
// - power reset restores all reset values; peripheral soft reset restores them, except debug control, the command strobe and the read data register
// - a one in the clear alias clears that bit in both views
// - a one in the set alias sets that bit in both views
// - both aliases read the same underlying value
// - simultaneous set and clear writes: clear takes precedence
`timescale 1ns/1ps
module rac_bank (
   // clock, reset, enable
   input wire logic i_clk,
   input wire logic i_rst_n,
   input wire logic i_ce,
   // write port a (cpu)
   input wire logic i_wr_a_en,
   input wire logic [rac_pkg::ADDR_W-1:0] i_wr_a_addr,
   input wire logic [rac_pkg::DATA_W-1:0] i_wr_a_data,
   // write port b (second master)
   input wire logic i_wr_b_en,
   input wire logic [rac_pkg::ADDR_W-1:0] i_wr_b_addr,
   input wire logic [rac_pkg::DATA_W-1:0] i_wr_b_data,
   // read port
   input wire logic i_rd_en,
   input wire logic [rac_pkg::ADDR_W-1:0] i_rd_addr,
   output logic [rac_pkg::DATA_W-1:0] o_rdata,
   // hardware status from core logic
   input wire logic i_busy,
   input wire logic [1:0] i_level,
   // control outputs
   output logic o_enable,
   output logic [1:0] o_mode,
   output logic o_run_in_debug,
   output logic o_cmd_strobe,
   output logic [rac_pkg::DATA_W-1:0] o_out
);
   logic [7:0] ctrl_reg;
   logic [7:0] status_reg;
   logic [7:0] status_next;
   logic [7:0] dbg_reg;
   logic [7:0] rdata_reg;
   logic [7:0] rdata_next;
   logic strobe_reg;
   logic [7:0] out_q;
   logic wa_ctrl;
   logic wb_ctrl;
   logic wa_dbg;
   logic wb_dbg;
   logic wa_cmd;
   logic wb_cmd;
   logic soft_rst;
   logic cmd_strobe;
   logic [7:0] set_mask;
   logic [7:0] clear_mask;
   logic [1:0] level_legal;

   // ********************************************************
   // write decode
   // ********************************************************
   assign wa_ctrl = i_wr_a_en && (i_wr_a_addr == rac_pkg::CTRL_ADDR);
   assign wb_ctrl = i_wr_b_en && (i_wr_b_addr == rac_pkg::CTRL_ADDR);
   assign wa_dbg = i_wr_a_en && (i_wr_a_addr == rac_pkg::DBGCTRL_ADDR);
   assign wb_dbg = i_wr_b_en && (i_wr_b_addr == rac_pkg::DBGCTRL_ADDR);
   assign wa_cmd = i_wr_a_en && (i_wr_a_addr == rac_pkg::CMD_ADDR);
   assign wb_cmd = i_wr_b_en && (i_wr_b_addr == rac_pkg::CMD_ADDR);
   assign soft_rst = (wa_cmd && i_wr_a_data[rac_pkg::CMD_SWRST_BIT])
      || (wb_cmd && i_wr_b_data[rac_pkg::CMD_SWRST_BIT]);
   assign cmd_strobe = (wa_cmd && i_wr_a_data[rac_pkg::CMD_STROBE_BIT])
      || (wb_cmd && i_wr_b_data[rac_pkg::CMD_STROBE_BIT]);

   // ********************************************************
   // control register: r/w, reserved bits never stored
   // ********************************************************
   // port a wins when both masters hit the same plain register
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         ctrl_reg <= rac_pkg::CTRL_RST;
      end else if (i_ce) begin
         if (soft_rst) begin
            ctrl_reg <= rac_pkg::CTRL_RST;
         end else if (wa_ctrl) begin
            ctrl_reg <= i_wr_a_data & rac_pkg::CTRL_MASK;
         end else if (wb_ctrl) begin
            ctrl_reg <= i_wr_b_data & rac_pkg::CTRL_MASK;
         end
      end
   end

   // ********************************************************
   // debug control: only power reset touches it
   // ********************************************************
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         dbg_reg <= rac_pkg::DBG_RST;
      end else if (i_ce) begin
         // soft reset deliberately not applied here
         if (wa_dbg) begin
            dbg_reg <= i_wr_a_data & rac_pkg::DBG_MASK;
         end else if (wb_dbg) begin
            dbg_reg <= i_wr_b_data & rac_pkg::DBG_MASK;
         end
      end
   end

   // ********************************************************
   // status: read-only, fed by hardware only
   // ********************************************************
   // reserved level code saturates so software never sees it
   assign level_legal = (i_level == rac_pkg::LEVEL_RESERVED) ? rac_pkg::LEVEL_MAX : i_level;
   assign status_next = {5'h00, level_legal, i_busy};

   // no write path exists, so writes to this index vanish
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         status_reg <= rac_pkg::STATUS_RST;
      end else if (i_ce) begin
         if (soft_rst) begin
            status_reg <= rac_pkg::STATUS_RST;
         end else begin
            status_reg <= status_next;
         end
      end
   end

   // ********************************************************
   // command register: write-only, one-cycle strobe
   // ********************************************************
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         strobe_reg <= 1'b0;
      end else if (i_ce) begin
         strobe_reg <= cmd_strobe;
      end
   end

   // ********************************************************
   // set/clear output pair
   // ********************************************************
   assign set_mask = ((i_wr_a_en && (i_wr_a_addr == rac_pkg::OUT_SET_ADDR)) ? i_wr_a_data : 8'h00)
      | ((i_wr_b_en && (i_wr_b_addr == rac_pkg::OUT_SET_ADDR)) ? i_wr_b_data : 8'h00);
   assign clear_mask = ((i_wr_a_en && (i_wr_a_addr == rac_pkg::CLEAR_ALIAS_REGISTER_ADDR)) ? i_wr_a_data : 8'h00)
      | ((i_wr_b_en && (i_wr_b_addr == rac_pkg::CLEAR_ALIAS_REGISTER_ADDR)) ? i_wr_b_data : 8'h00);

   rac_setclr #(
      .WIDTH(rac_pkg::DATA_W),
      .RST_VAL(rac_pkg::OUT_RST)
   ) u_out_pair (
      .i_clk(i_clk),
      .i_rst_n(i_rst_n),
      .i_ce(i_ce),
      .i_soft_rst(soft_rst),
      .i_set_mask(set_mask),
      .i_clear_mask(clear_mask),
      .o_q(out_q)
   );

   // ********************************************************
   // read mux, one cycle latency
   // ********************************************************
   // write-only command reads as zero; software must not count on it
   always_comb begin
      case (i_rd_addr)
         rac_pkg::CTRL_ADDR: rdata_next = ctrl_reg & rac_pkg::CTRL_MASK;
         rac_pkg::STATUS_ADDR: rdata_next = status_reg & rac_pkg::STATUS_MASK;
         rac_pkg::CMD_ADDR: rdata_next = 8'h00;
         rac_pkg::DBGCTRL_ADDR: rdata_next = dbg_reg & rac_pkg::DBG_MASK;
         rac_pkg::OUT_SET_ADDR: rdata_next = out_q;
         rac_pkg::CLEAR_ALIAS_REGISTER_ADDR: rdata_next = out_q;
         default: rdata_next = 8'h00;
      endcase
   end

   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         rdata_reg <= rac_pkg::RDATA_RST;
      end else if (i_ce && i_rd_en) begin
         rdata_reg <= rdata_next;
      end
   end

   assign o_rdata = rdata_reg;
   assign o_enable = ctrl_reg[rac_pkg::CTRL_ENABLE_BIT];
   assign o_mode = ctrl_reg[rac_pkg::CTRL_MODE_MSB:rac_pkg::CTRL_MODE_LSB];
   assign o_run_in_debug = dbg_reg[rac_pkg::DBG_RUN_BIT];
   assign o_cmd_strobe = strobe_reg;
   assign o_out = out_q;

   // ********************************************************
   // checks
   // ********************************************************
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_rst_n);

   sequence s_rd(logic [2:0] a);
      i_ce && i_rd_en && (i_rd_addr == a);
   endsequence

   sequence s_soft_rst;
      i_ce && soft_rst;
   endsequence

   a_ro_write_ignored: assert property (s_rd(rac_pkg::STATUS_ADDR) ##0 (i_wr_a_en || i_wr_b_en)
      |=> o_rdata == ($past(status_reg) & rac_pkg::STATUS_MASK))
      else $error("status read disturbed by a write");
   a_wo_read_zero: assert property (s_rd(rac_pkg::CMD_ADDR) |=> o_rdata == 8'h00)
      else $error("command register read not zero");
   a_rsvd_read_zero: assert property (s_rd(rac_pkg::CTRL_ADDR) |=> (o_rdata & ~rac_pkg::CTRL_MASK) == 8'h00)
      else $error("reserved control bits read nonzero");
   a_level_never_rsvd: assert property (status_reg[2:1] != rac_pkg::LEVEL_RESERVED)
      else $error("reserved level code visible");
   a_soft_rst_restore: assert property (s_soft_rst |=> (ctrl_reg == rac_pkg::CTRL_RST)
      && (out_q == rac_pkg::OUT_RST) && (status_reg == rac_pkg::STATUS_RST)
      && ($stable(dbg_reg) || $past(wa_dbg || wb_dbg)))
      else $error("soft reset did not restore values");
   a_power_rst_value: assert property (disable iff (1'b0) !i_rst_n |=> (ctrl_reg == rac_pkg::CTRL_RST)
      && (dbg_reg == rac_pkg::DBG_RST) && (out_q == rac_pkg::OUT_RST))
      else $error("power reset value wrong");
   a_alias_same_value: assert property ((s_rd(rac_pkg::OUT_SET_ADDR) or s_rd(rac_pkg::CLEAR_ALIAS_REGISTER_ADDR))
      |=> o_rdata == $past(out_q))
      else $error("alias read differs from stored value");
   a_double_write_clear: assert property (i_ce && !soft_rst && ((set_mask & clear_mask) != 8'h00)
      |=> (out_q & $past(set_mask & clear_mask)) == 8'h00)
      else $error("clear lost to set on same cycle");
endmodule // rac_bank

// ---- test/tb.sv ----
// self-checking testbench for the register access conventions bank
`timescale 1ns/1ps
module tb;
   logic i_clk = 1'b0;
   logic i_rst_n = 1'b0;
   logic i_ce = 1'b1;
   logic i_wr_a_en = 1'b0;
   logic [2:0] i_wr_a_addr = 3'h0;
   logic [7:0] i_wr_a_data = 8'h00;
   logic i_wr_b_en = 1'b0;
   logic [2:0] i_wr_b_addr = 3'h0;
   logic [7:0] i_wr_b_data = 8'h00;
   logic i_rd_en = 1'b0;
   logic [2:0] i_rd_addr = 3'h0;
   logic [7:0] o_rdata;
   logic i_busy = 1'b0;
   logic [1:0] i_level = 2'h0;
   logic o_enable;
   logic [1:0] o_mode;
   logic o_run_in_debug;
   logic o_cmd_strobe;
   logic [7:0] o_out;
   int n_fail = 0;
   int compares = 0;

   always #12.5 i_clk = ~i_clk;

   rac_bank DUT (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_ce(i_ce),
      .i_wr_a_en(i_wr_a_en), .i_wr_a_addr(i_wr_a_addr), .i_wr_a_data(i_wr_a_data),
      .i_wr_b_en(i_wr_b_en), .i_wr_b_addr(i_wr_b_addr), .i_wr_b_data(i_wr_b_data),
      .i_rd_en(i_rd_en), .i_rd_addr(i_rd_addr), .o_rdata(o_rdata), .i_busy(i_busy), .i_level(i_level),
      .o_enable(o_enable), .o_mode(o_mode), .o_run_in_debug(o_run_in_debug),
      .o_cmd_strobe(o_cmd_strobe), .o_out(o_out));

   // ********************************************************
   // shared tasks
   // ********************************************************
   // inputs always change 1 ns after the rising edge
   task automatic step();
      @(posedge i_clk);
      #1;
   endtask

   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      compares++;
      if (seen !== exp) begin
         n_fail++;
         $display("BAD %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic wr_ab(input logic ea, input logic [2:0] aa, input logic [7:0] ad,
                        input logic eb, input logic [2:0] ba, input logic [7:0] bd);
      // idle edge first: a following call never re-raises a strobe in the same step
      step();
      i_wr_a_en = ea;
      i_wr_a_addr = aa;
      i_wr_a_data = ad;
      i_wr_b_en = eb;
      i_wr_b_addr = ba;
      i_wr_b_data = bd;
      step();
      i_wr_a_en = 1'b0;
      i_wr_b_en = 1'b0;
   endtask

   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      wr_ab(1'b1, a, d, 1'b0, 3'h0, 8'h00);
   endtask

   // read data is registered: valid right after the taking edge
   task automatic rd(input logic [2:0] a, input logic [7:0] exp);
      step();
      i_rd_en = 1'b1;
      i_rd_addr = a;
      step();
      i_rd_en = 1'b0;
      check(o_rdata, exp);
   endtask

   task automatic finish_test();
      $display("compares %0d n_fail %0d", compares, n_fail);
      if (n_fail == 0 && compares > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   // ********************************************************
   // scenarios
   // ********************************************************
   task automatic t_reset_values();
      check(o_out, 8'h00);
      check({6'h0, o_mode}, 8'h00);
      for (int i = 0; i < 8; i++) rd(3'(i), 8'h00);
   endtask

   // status is read-only and saturates the reserved level code
   task automatic t_status();
      logic [1:0] lv;
      i_busy = 1'b1;
      for (int i = 0; i < 4; i++) begin
         lv = 2'(i);
         i_level = lv;
         wr(rac_pkg::STATUS_ADDR, 8'hf8);
         step();
         rd(rac_pkg::STATUS_ADDR, {5'h00, (lv == 2'h3) ? 2'h2 : lv, 1'b1});
      end
      // write and read status on one edge: the stored value must come back
      step();
      i_wr_b_en = 1'b1;
      i_wr_b_addr = rac_pkg::STATUS_ADDR;
      i_wr_b_data = 8'h02;
      i_rd_en = 1'b1;
      i_rd_addr = rac_pkg::STATUS_ADDR;
      step();
      i_wr_b_en = 1'b0;
      i_rd_en = 1'b0;
      check(o_rdata, 8'h05);
      i_busy = 1'b0;
   endtask

   // reserved bits and unmapped places read zero; write-only reads no set bits
   task automatic t_reserved_wo();
      // no fuse locations in this bank; the bench writes none
      wr(rac_pkg::CTRL_ADDR, 8'hff);
      rd(rac_pkg::CTRL_ADDR, 8'h0d);
      check({5'h00, o_mode, o_enable}, 8'h07);
      wr(3'h6, 8'hff);
      rd(3'h6, 8'h00);
      wr(rac_pkg::CMD_ADDR, 8'h02);
      check({7'h00, o_cmd_strobe}, 8'h01);
      step();
      check({7'h00, o_cmd_strobe}, 8'h00);
      rd(rac_pkg::CMD_ADDR, 8'h00);
   endtask

   task automatic t_set_clear();
      wr_ab(1'b0, 3'h0, 8'h00, 1'b1, rac_pkg::OUT_SET_ADDR, 8'h05);
      rd(rac_pkg::OUT_SET_ADDR, 8'h05);
      rd(rac_pkg::CLEAR_ALIAS_REGISTER_ADDR, 8'h05);
      wr(rac_pkg::OUT_SET_ADDR, 8'h00);
      check(o_out, 8'h05);
      wr(rac_pkg::CLEAR_ALIAS_REGISTER_ADDR, 8'h01);
      check(o_out, 8'h04);
      rd(rac_pkg::OUT_SET_ADDR, 8'h04);
      wr(rac_pkg::CLEAR_ALIAS_REGISTER_ADDR, 8'h00);
      check(o_out, 8'h04);
      wr_ab(1'b1, rac_pkg::OUT_SET_ADDR, 8'h0f, 1'b1, rac_pkg::CLEAR_ALIAS_REGISTER_ADDR, 8'h06);
      check(o_out, 8'h09);
   endtask

   // frozen clock enable drops a write
   task automatic t_ce_hold();
      i_ce = 1'b0;
      wr(rac_pkg::CTRL_ADDR, 8'h01);
      i_ce = 1'b1;
      rd(rac_pkg::CTRL_ADDR, 8'h0d);
   endtask

   // soft reset keeps debug control, power reset does not
   task automatic t_soft_reset();
      wr(rac_pkg::DBGCTRL_ADDR, 8'h01);
      wr(rac_pkg::OUT_SET_ADDR, 8'hff);
      wr(rac_pkg::CMD_ADDR, 8'h01);
      check(o_out, 8'h00);
      check({7'h00, o_enable}, 8'h00);
      check({7'h00, o_run_in_debug}, 8'h01);
      rd(rac_pkg::DBGCTRL_ADDR, 8'h01);
      rd(rac_pkg::CTRL_ADDR, 8'h00);
      i_rst_n = 1'b0;
      step();
      i_rst_n = 1'b1;
      check({7'h00, o_run_in_debug}, 8'h00);
      rd(rac_pkg::DBGCTRL_ADDR, 8'h00);
   endtask

   // hang guard; the sequence needs far fewer cycles
   initial begin
      repeat (5000) @(posedge i_clk);
      n_fail++;
      finish_test();
   end

   initial begin
      repeat (2) @(posedge i_clk);
      #1;
      i_rst_n = 1'b1;
      t_reset_values();
      t_status();
      t_reserved_wo();
      t_set_clear();
      t_ce_hold();
      t_soft_reset();
      finish_test();
   end
endmodule // tb
